// file: rtl/jle_core.sv
// Summary of operation
// RULE1 - Codes 00000..01000 test always, Z, /Z, /N, N, C, /C, V, /V.
// RULE2 - 01101 is /C and /Z, 01110 is C or Z, 01111 is /N and /Z.
// RULE3 - 01001 signed greater: Z clear and N equals V.
// RULE4 - 01010 true when N equals V; 01011 true when they differ.
// RULE5 - 01100 true when Z set or N differs from V.
// RULE6 - Condition true jumps to the source address, else fall through.
// RULE7 - Any target address allowed, forced to 16-bit alignment.
// RULE8 - Plain forms skip next instruction when taken; delayed forms run it. A taken delayed return jump skips it here.
// RULE9 - Jump, branch, loop, return or long immediate in a slot faults.
// RULE10 - Software never targets a delay-slot instruction with a jump.
// RULE11 - Flag-setting return jump loads PC from link, status from saved.
// RULE12 - Return jump also restores branch target from its level's copy.
// RULE13 - Return sets Z,N,C,V from bits 11..8 and enables from 2,1.
// RULE14 - Return jumps carry set-flags; the reserved field is ignored.
// RULE15 - Link source without set-flags, or set-flags otherwise, faults.
// RULE16 - Restored slot-pending bit resumes a delayed branch to target.
// RULE17 - Software separates flag or saved-status writes from a return.
// RULE18 - Taken jump-and-link writes the return address to r31.
// RULE19 - Delayed link stores next PC plus 4; plain stores next PC.
// RULE20 - Other jumps and all link forms keep the four flags.
`timescale 1ns/10ps
module jle_core (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic inst_valid,
  input wire logic inst_is_jump,
  input wire logic inst_is_link,
  input wire logic inst_delayed,
  input wire logic [4:0] inst_cond,
  input wire logic inst_set_flags,
  input wire jle_pkg::jle_src_t inst_src,
  input wire logic [31:0] inst_src_value,
  input wire logic inst_src_limm,
  input wire logic [31:0] inst_next_pc,
  input wire logic inst_other_branch,
  input wire logic inst_is_loop,
  input wire logic inst_is_irq_return,
  output logic redirect_valid,
  output logic [31:0] redirect_pc,
  output logic kill_next,
  output logic fault_illegal_seq,
  output logic fault_instr_error,
  output logic link_we,
  output logic [31:0] link_value,
  output logic [31:0] main_status_word,
  output logic slot_active
);

  // ****************************************
  // State and condition evaluator
  // ****************************************
  jle_pkg::jle_state_t st_reg;
  jle_pkg::jle_state_t st_next;
  jle_cond_if cc ();
  logic from_ret;
  logic slot_bad;
  logic flag_fault;
  logic go;
  logic taken;
  logic ret_taken;
  logic [31:0] target;
  logic [31:0] saved_status;
  logic [31:0] saved_target;
  logic [31:0] rd_mux;
  logic rd_hit;
  logic apb_wr;
  logic status_wr;

  jle_cond_eval u_cond (.cc(cc));

  assign cc.cond = inst_cond;
  assign cc.zero = st_reg.main_status_word[jle_pkg::ZERO_BIT];
  assign cc.neg = st_reg.main_status_word[jle_pkg::NEG_BIT];
  assign cc.carry = st_reg.main_status_word[jle_pkg::CARRY_BIT];
  assign cc.ovfl = st_reg.main_status_word[jle_pkg::OVFL_BIT];

  // ****************************************
  // Decode of the issued instruction
  // ****************************************
  assign from_ret = (inst_src != jle_pkg::JLE_SRC_PLAIN);
  // Slot check sees the jump itself too, so nested jumps always fault
  assign slot_bad = st_reg.slot_active && (inst_is_jump || inst_other_branch
    || inst_is_loop || inst_is_irq_return || inst_src_limm); // [RULE9]
  // Reserved field is never looked at, only the set-flags bit
  assign flag_fault = inst_is_jump && (from_ret != inst_set_flags); // [RULE15] [RULE14]
  assign go = inst_valid && !slot_bad && !flag_fault;
  assign taken = go && inst_is_jump && cc.holds; // [RULE6]
  assign ret_taken = taken && from_ret && !inst_is_link; // [RULE20]
  assign target = inst_src_value & jle_pkg::ALIGN_MASK; // [RULE7]
  assign saved_status = (inst_src == jle_pkg::JLE_SRC_LVL2_RET) ?
    st_reg.level2_saved_status : st_reg.level1_saved_status;
  assign saved_target = (inst_src == jle_pkg::JLE_SRC_LVL2_RET) ?
    st_reg.level2_saved_branch_target : st_reg.level1_saved_branch_target;

  // ****************************************
  // APB slave
  // ****************************************
  // Read data is caught in the setup cycle so the access phase answers at once
  assign pready = 1'b1;
  assign apb_wr = psel && penable && pwrite;
  assign status_wr = apb_wr && (paddr == jle_pkg::OFF_MAIN_STATUS);

  always_comb begin
    rd_hit = 1'b1;
    unique case (paddr)
      jle_pkg::OFF_MAIN_STATUS: rd_mux = st_reg.main_status_word;
      jle_pkg::OFF_L1_STATUS: rd_mux = st_reg.level1_saved_status;
      jle_pkg::OFF_L2_STATUS: rd_mux = st_reg.level2_saved_status;
      jle_pkg::OFF_BRANCH_TARGET: rd_mux = st_reg.branch_target_holder;
      jle_pkg::OFF_L1_TARGET: rd_mux = st_reg.level1_saved_branch_target;
      jle_pkg::OFF_L2_TARGET: rd_mux = st_reg.level2_saved_branch_target;
      jle_pkg::OFF_RETURN_LINK: rd_mux = st_reg.return_link;
      jle_pkg::OFF_FAULT: rd_mux = {30'h0000_0000, st_reg.fault_sticky};
      default: begin
        rd_mux = jle_pkg::WORD_RESET;
        rd_hit = 1'b0;
      end
    endcase
  end

  // ****************************************
  // Next-state logic
  // ****************************************
  always_comb begin
    st_next = st_reg;
    st_next.redirect_valid = 1'b0;
    st_next.kill_next = 1'b0;
    st_next.fault_seq = 1'b0;
    st_next.fault_err = 1'b0;
    st_next.link_we = 1'b0;
    if (psel && !penable) begin
      st_next.prdata = rd_mux;
      st_next.pslverr = !rd_hit;
    end
    // Software writes first; instruction effects below take priority
    if (apb_wr) begin
      unique case (paddr)
        jle_pkg::OFF_MAIN_STATUS: st_next.main_status_word = pwdata;
        jle_pkg::OFF_L1_STATUS: st_next.level1_saved_status = pwdata;
        jle_pkg::OFF_L2_STATUS: st_next.level2_saved_status = pwdata;
        jle_pkg::OFF_BRANCH_TARGET: st_next.branch_target_holder = pwdata;
        jle_pkg::OFF_L1_TARGET: st_next.level1_saved_branch_target = pwdata;
        jle_pkg::OFF_L2_TARGET: st_next.level2_saved_branch_target = pwdata;
        jle_pkg::OFF_FAULT: st_next.fault_sticky = st_reg.fault_sticky
          & ~pwdata[1:0];
        default: st_next.pslverr = st_reg.pslverr;
      endcase
    end
    if (inst_valid && slot_bad) begin
      st_next.fault_seq = 1'b1; // [RULE9]
      st_next.slot_active = 1'b0;
      st_next.main_status_word[jle_pkg::DELAY_SLOT_PENDING_BIT] = 1'b0;
    end else if (inst_valid && flag_fault) begin
      st_next.fault_err = 1'b1; // [RULE15]
    end else if (go) begin
      if (st_reg.slot_active) begin
        st_next.slot_active = 1'b0;
        if (st_reg.main_status_word[jle_pkg::DELAY_SLOT_PENDING_BIT]) begin
          st_next.redirect_valid = 1'b1; // [RULE16]
          st_next.redirect_pc = st_reg.branch_target_holder;
          st_next.main_status_word[jle_pkg::DELAY_SLOT_PENDING_BIT] = 1'b0;
        end
      end
      if (inst_is_jump && inst_delayed) begin
        st_next.slot_active = 1'b1; // [RULE8]
      end
      if (taken && inst_delayed && !ret_taken) begin
        st_next.branch_target_holder = target; // [RULE6] [RULE8]
        st_next.main_status_word[jle_pkg::DELAY_SLOT_PENDING_BIT] = 1'b1;
      end else if (taken) begin
        st_next.redirect_valid = 1'b1; // [RULE6] [RULE8]
        st_next.redirect_pc = target;
        st_next.kill_next = 1'b1;
      end
      if (ret_taken) begin
        // Whole saved word, so flags 11..8 and enables 2,1 come along
        st_next.main_status_word = saved_status; // [RULE11] [RULE13]
        st_next.branch_target_holder = saved_target; // [RULE12]
        st_next.slot_active =
          saved_status[jle_pkg::DELAY_SLOT_PENDING_BIT]; // [RULE16]
      end
      if (taken && inst_is_link) begin
        st_next.link_we = 1'b1; // [RULE18]
        st_next.return_link = inst_delayed ?
          inst_next_pc + jle_pkg::SLOT_SKIP : inst_next_pc; // [RULE19]
      end
    end
    // A fault in the same cycle as a software clear stays set
    if (st_next.fault_seq) begin
      st_next.fault_sticky[jle_pkg::FAULT_SEQ_BIT] = 1'b1;
    end
    if (st_next.fault_err) begin
      st_next.fault_sticky[jle_pkg::FAULT_ERR_BIT] = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '0;
      st_reg.main_status_word <= jle_pkg::STATUS_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign prdata = st_reg.prdata;
  assign pslverr = st_reg.pslverr;
  assign redirect_valid = st_reg.redirect_valid;
  assign redirect_pc = st_reg.redirect_pc;
  assign kill_next = st_reg.kill_next;
  assign fault_illegal_seq = st_reg.fault_seq;
  assign fault_instr_error = st_reg.fault_err;
  assign link_we = st_reg.link_we;
  assign link_value = st_reg.return_link;
  assign main_status_word = st_reg.main_status_word;
  assign slot_active = st_reg.slot_active;

  // ****************************************
  // Assertions
  // ****************************************
  property p_cond_basic;
    @(posedge pclk) disable iff (!presetn)
    (cc.cond == 5'h00 || (cc.cond == 5'h01 && cc.zero)
      || (cc.cond == 5'h06 && !cc.carry)) |-> cc.holds;
  endproperty
  a_cond_basic: assert property (p_cond_basic) // [RULE1]
    else $error("basic condition not true");

  property p_cond_unsigned;
    @(posedge pclk) disable iff (!presetn)
    (cc.cond == 5'h0D) |-> (cc.holds == (!cc.carry && !cc.zero));
  endproperty
  a_cond_unsigned: assert property (p_cond_unsigned) // [RULE2]
    else $error("higher-than condition wrong");

  property p_cond_gt;
    @(posedge pclk) disable iff (!presetn)
    (cc.cond == 5'h09) |-> (cc.holds == (!cc.zero && cc.neg == cc.ovfl));
  endproperty
  a_cond_gt: assert property (p_cond_gt) // [RULE3]
    else $error("signed greater condition wrong");

  property p_cond_lt;
    @(posedge pclk) disable iff (!presetn)
    (cc.cond == 5'h0B) |-> (cc.holds == (cc.neg != cc.ovfl));
  endproperty
  a_cond_lt: assert property (p_cond_lt) // [RULE4]
    else $error("signed less condition wrong");

  property p_cond_le;
    @(posedge pclk) disable iff (!presetn)
    (cc.cond == 5'h0C && cc.zero) |-> cc.holds;
  endproperty
  a_cond_le: assert property (p_cond_le) // [RULE5]
    else $error("signed less-or-equal condition wrong");

  property p_plain_jump;
    @(posedge pclk) disable iff (!presetn)
    (taken && !inst_delayed && !from_ret) |=> (redirect_valid && kill_next
      && redirect_pc == ($past(inst_src_value) & 32'hFFFF_FFFE));
  endproperty
  a_plain_jump: assert property (p_plain_jump) // [RULE6] [RULE7] [RULE8]
    else $error("plain jump did not redirect to aligned target");

  property p_slot_fault;
    @(posedge pclk) disable iff (!presetn)
    (inst_valid && slot_active && inst_src_limm) |=> (fault_illegal_seq
      && !slot_active && !redirect_valid);
  endproperty
  a_slot_fault: assert property (p_slot_fault) // [RULE9]
    else $error("illegal slot content not faulted");

  property p_ret_restore;
    @(posedge pclk) disable iff (!presetn)
    (ret_taken && inst_src == jle_pkg::JLE_SRC_LVL1_RET) |=>
      (main_status_word == $past(st_reg.level1_saved_status)
      && st_reg.branch_target_holder
        == $past(st_reg.level1_saved_branch_target));
  endproperty
  a_ret_restore: assert property (p_ret_restore) // [RULE11] [RULE12] [RULE13]
    else $error("interrupt return did not restore state");

  property p_flag_fault;
    @(posedge pclk) disable iff (!presetn)
    (inst_valid && !slot_active && inst_is_jump && inst_set_flags
      && !from_ret) |=> (fault_instr_error && !redirect_valid && !link_we);
  endproperty
  a_flag_fault: assert property (p_flag_fault) // [RULE15]
    else $error("set-flags misuse not faulted");

  property p_resume_slot;
    @(posedge pclk) disable iff (!presetn)
    (go && slot_active && main_status_word[jle_pkg::DELAY_SLOT_PENDING_BIT])
      |=> (redirect_valid
      && redirect_pc == $past(st_reg.branch_target_holder));
  endproperty
  a_resume_slot: assert property (p_resume_slot) // [RULE16] [RULE8]
    else $error("pending delayed branch not taken after slot");

  property p_resume_first;
    @(posedge pclk) disable iff (!presetn)
    (ret_taken && saved_status[jle_pkg::DELAY_SLOT_PENDING_BIT])
      |=> slot_active;
  endproperty
  a_resume_first: assert property (p_resume_first) // [RULE16]
    else $error("restored pending slot not resumed");

  property p_link_value;
    @(posedge pclk) disable iff (!presetn)
    (taken && inst_is_link && inst_delayed) |=> (link_we
      && link_value == $past(inst_next_pc) + 32'h0000_0004);
  endproperty
  a_link_value: assert property (p_link_value) // [RULE18] [RULE19]
    else $error("delayed link return address wrong");

  property p_flags_kept;
    @(posedge pclk) disable iff (!presetn)
    (!ret_taken && !status_wr) |=>
      $stable(main_status_word[11:8]);
  endproperty
  a_flags_kept: assert property (p_flags_kept) // [RULE20]
    else $error("flags changed without interrupt return");

endmodule

// file: shared/jle_pkg.sv
package jle_pkg;

  // ****************************************
  // Register map (APB byte addresses)
  // ****************************************
  localparam logic [7:0] OFF_MAIN_STATUS = 8'h00;
  localparam logic [7:0] OFF_L1_STATUS = 8'h04;
  localparam logic [7:0] OFF_L2_STATUS = 8'h08;
  localparam logic [7:0] OFF_BRANCH_TARGET = 8'h0C;
  localparam logic [7:0] OFF_L1_TARGET = 8'h10;
  localparam logic [7:0] OFF_L2_TARGET = 8'h14;
  localparam logic [7:0] OFF_RETURN_LINK = 8'h18;
  localparam logic [7:0] OFF_FAULT = 8'h1C;

  // ****************************************
  // Status word and fault register fields
  // ****************************************
  localparam int ZERO_BIT = 11;
  localparam int NEG_BIT = 10;
  localparam int CARRY_BIT = 9;
  localparam int OVFL_BIT = 8;
  localparam int DELAY_SLOT_PENDING_BIT = 6;
  localparam int LEVEL2_IRQ_ENABLE_BIT = 2;
  localparam int LEVEL1_IRQ_ENABLE_BIT = 1;
  localparam int FAULT_SEQ_BIT = 0;
  localparam int FAULT_ERR_BIT = 1;

  localparam logic [31:0] STATUS_RESET = 32'h0000_0000;
  localparam logic [31:0] WORD_RESET = 32'h0000_0000;
  localparam logic [31:0] ALIGN_MASK = 32'hFFFF_FFFE;
  localparam logic [31:0] SLOT_SKIP = 32'h0000_0004;

  // ****************************************
  // Condition codes and jump sources
  // ****************************************
  typedef enum logic [4:0] {
    JLE_CC_AL = 5'h00, JLE_CC_EQ = 5'h01, JLE_CC_NE = 5'h02,
    JLE_CC_PL = 5'h03, JLE_CC_MI = 5'h04, JLE_CC_CS = 5'h05,
    JLE_CC_CC = 5'h06, JLE_CC_VS = 5'h07, JLE_CC_VC = 5'h08,
    JLE_CC_GT = 5'h09, JLE_CC_GE = 5'h0A, JLE_CC_LT = 5'h0B,
    JLE_CC_LE = 5'h0C, JLE_CC_HI = 5'h0D, JLE_CC_LS = 5'h0E,
    JLE_CC_POS_NONZERO = 5'h0F
  } jle_cc_t;

  typedef enum logic [1:0] {
    JLE_SRC_PLAIN = 2'h0,
    JLE_SRC_LVL1_RET = 2'h1,
    JLE_SRC_LVL2_RET = 2'h2
  } jle_src_t;

  typedef struct packed {
    logic [31:0] main_status_word;
    logic [31:0] level1_saved_status;
    logic [31:0] level2_saved_status;
    logic [31:0] branch_target_holder;
    logic [31:0] level1_saved_branch_target;
    logic [31:0] level2_saved_branch_target;
    logic [31:0] return_link;
    logic [1:0] fault_sticky;
    logic slot_active;
    logic redirect_valid;
    logic [31:0] redirect_pc;
    logic kill_next;
    logic fault_seq;
    logic fault_err;
    logic link_we;
    logic [31:0] prdata;
    logic pslverr;
  } jle_state_t;

endpackage

// file: shared/jle_cond_if.sv
`timescale 1ns/10ps
interface jle_cond_if;
  logic [4:0] cond;
  logic zero;
  logic neg;
  logic carry;
  logic ovfl;
  logic holds;

  modport requester (output cond, zero, neg, carry, ovfl, input holds);
  modport evaluator (input cond, zero, neg, carry, ovfl, output holds);
endinterface

// file: rtl/jle_cond_eval.sv
`timescale 1ns/10ps
module jle_cond_eval (
  jle_cond_if.evaluator cc
);

  // ****************************************
  // Condition test
  // ****************************************
  // Codes above 01111 are extension conditions; none exist here, so false
  always_comb begin
    unique case (cc.cond)
      jle_pkg::JLE_CC_AL: cc.holds = 1'b1; // [RULE1]
      jle_pkg::JLE_CC_EQ: cc.holds = cc.zero; // [RULE1]
      jle_pkg::JLE_CC_NE: cc.holds = !cc.zero; // [RULE1]
      jle_pkg::JLE_CC_PL: cc.holds = !cc.neg; // [RULE1]
      jle_pkg::JLE_CC_MI: cc.holds = cc.neg; // [RULE1]
      jle_pkg::JLE_CC_CS: cc.holds = cc.carry; // [RULE1]
      jle_pkg::JLE_CC_CC: cc.holds = !cc.carry; // [RULE1]
      jle_pkg::JLE_CC_VS: cc.holds = cc.ovfl; // [RULE1]
      jle_pkg::JLE_CC_VC: cc.holds = !cc.ovfl; // [RULE1]
      jle_pkg::JLE_CC_GT: cc.holds = !cc.zero && (cc.neg == cc.ovfl); // [RULE3]
      jle_pkg::JLE_CC_GE: cc.holds = (cc.neg == cc.ovfl); // [RULE4]
      jle_pkg::JLE_CC_LT: cc.holds = (cc.neg != cc.ovfl); // [RULE4]
      jle_pkg::JLE_CC_LE: cc.holds = cc.zero || (cc.neg != cc.ovfl); // [RULE5]
      jle_pkg::JLE_CC_HI: cc.holds = !cc.carry && !cc.zero; // [RULE2]
      jle_pkg::JLE_CC_LS: cc.holds = cc.carry || cc.zero; // [RULE2]
      jle_pkg::JLE_CC_POS_NONZERO: cc.holds = !cc.neg && !cc.zero; // [RULE2]
      default: cc.holds = 1'b0;
    endcase
  end

endmodule

// file: verification/jump_and_link_execution_bench.sv
`timescale 1ns/10ps
module jump_and_link_execution_bench;
  // ****************************************
  // Signals
  // ****************************************
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic inst_valid = 1'b0, inst_is_jump = 1'b0, inst_is_link = 1'b0;
  logic inst_delayed = 1'b0, inst_set_flags = 1'b0, inst_src_limm = 1'b0;
  logic inst_other_branch = 1'b0, inst_is_loop = 1'b0;
  logic inst_is_irq_return = 1'b0;
  logic [4:0] inst_cond = 5'h00;
  jle_pkg::jle_src_t inst_src = jle_pkg::JLE_SRC_PLAIN;
  logic [31:0] inst_src_value = 32'h0, inst_next_pc = 32'h0;
  logic [31:0] prdata, redirect_pc, link_value, main_status_word, rdv;
  logic pready, pslverr, redirect_valid, kill_next, link_we, slot_active;
  logic fault_illegal_seq, fault_instr_error, erv, e;
  int errors = 0;
  int n_tests = 0;

  jle_core jle_core_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .inst_valid, .inst_is_jump,
    .inst_is_link, .inst_delayed, .inst_cond, .inst_set_flags, .inst_src,
    .inst_src_value, .inst_src_limm, .inst_next_pc, .inst_other_branch,
    .inst_is_loop, .inst_is_irq_return, .redirect_valid, .redirect_pc,
    .kill_next, .fault_illegal_seq, .fault_instr_error, .link_we, .link_value,
    .main_status_word, .slot_active);

  initial begin
    forever #20 pclk = ~pclk;
  end

  // ****************************************
  // Tasks
  // ****************************************
  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH at %0t: word %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic check_bit(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH at %0t: flag %b, expected %b", $time, got, exp);
    end
  endtask

  task automatic end_test(input string name);
    $display("Test %s done at %0t", name, $time);
  endtask

  // Holds the request until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdv = prdata;
    erv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] x,
                        input logic xe);
    apb(1'b0, a, 32'h0);
    check_word(rdv, x);
    check_bit(erv, xe);
    check_bit(pready, 1'b1);
  endtask

  // Outputs are looked at 1 ns after the edge that takes the instruction
  task automatic issue(input logic [2:0] jld, input logic [4:0] cc,
                       input logic sf, input logic [1:0] src,
                       input logic [31:0] sv, input logic [31:0] np,
                       input logic [3:0] kind);
    @(posedge pclk);
    inst_valid <= 1'b1;
    {inst_is_jump, inst_is_link, inst_delayed} <= jld;
    inst_cond <= cc;
    inst_set_flags <= sf;
    inst_src <= jle_pkg::jle_src_t'(src);
    inst_src_value <= sv;
    inst_next_pc <= np;
    {inst_src_limm, inst_is_irq_return, inst_is_loop,
     inst_other_branch} <= kind;
    @(posedge pclk);
    inst_valid <= 1'b0;
    #1;
  endtask

  function automatic logic cc_true(input logic [4:0] c, input logic [3:0] f);
    logic z, n, cy, v;
    {z, n, cy, v} = f;
    case (c)
      5'h00: return 1'b1;
      5'h01: return z;
      5'h02: return !z;
      5'h03: return !n;
      5'h04: return n;
      5'h05: return cy;
      5'h06: return !cy;
      5'h07: return v;
      5'h08: return !v;
      5'h09: return !z && (n == v);
      5'h0A: return n == v;
      5'h0B: return n != v;
      5'h0C: return z || (n != v);
      5'h0D: return !cy && !z;
      5'h0E: return cy || z;
      5'h0F: return !n && !z;
      default: return 1'b0;
    endcase
  endfunction

  // Restore from one interrupt level, then run the slot if one is pending
  task automatic ret_chk(input logic [1:0] lv, input logic [31:0] s,
                         input logic [31:0] t);
    apb(1'b1, lv == 2'h1 ? jle_pkg::OFF_L1_STATUS : jle_pkg::OFF_L2_STATUS, s);
    apb(1'b1, lv == 2'h1 ? jle_pkg::OFF_L1_TARGET : jle_pkg::OFF_L2_TARGET, t);
    apb(1'b1, jle_pkg::OFF_MAIN_STATUS, 32'h0);
    @(posedge pclk); // Quiet cycle before the return
    issue(3'b100, 5'h00, 1'b1, lv, 32'h0000_7001, 32'h50, 4'h0);
    check_bit(redirect_valid, 1'b1);
    check_word(redirect_pc, 32'h0000_7000);
    check_word(main_status_word, s);
    check_bit(slot_active, s[6]);
    rd_chk(jle_pkg::OFF_BRANCH_TARGET, t, 1'b0);
    issue(3'b000, 5'h00, 1'b0, 2'h0, 32'h0, 32'h0, 4'h0);
    check_bit(redirect_valid, s[6]);
    if (s[6]) check_word(redirect_pc, t);
    check_bit(main_status_word[6], 1'b0);
  endtask

  task automatic complete_run;
    $display("Comparisons %0d, mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      rd_chk(8'(i * 4), 32'h0, 1'b0);
    end
    rd_chk(8'h20, 32'h0, 1'b1);
    end_test("reset and map");
    // Code 10000 stands for the undefined codes, which never hold
    for (int c = 0; c < 17; c++) begin
      for (int f = 0; f < 16; f++) begin
        apb(1'b1, jle_pkg::OFF_MAIN_STATUS, {20'h0, f[3:0], 8'h0});
        e = cc_true(c[4:0], f[3:0]);
        issue(3'b100, c[4:0], 1'b0, 2'h0, {16'hF0F0, c[7:0], 8'h03},
              32'h100, 4'h0);
        check_bit(redirect_valid, e);
        check_bit(kill_next, e);
        if (e) check_word(redirect_pc, {16'hF0F0, c[7:0], 8'h02});
        check_word(main_status_word, {20'h0, f[3:0], 8'h0});
      end
    end
    end_test("conditions");
    issue(3'b110, 5'h00, 1'b0, 2'h0, 32'h0000_4003, 32'h2000, 4'h0);
    check_bit(link_we, 1'b1);
    check_word(link_value, 32'h0000_2000);
    check_word(redirect_pc, 32'h0000_4002);
    apb(1'b1, jle_pkg::OFF_MAIN_STATUS, 32'h0);
    issue(3'b110, 5'h01, 1'b0, 2'h0, 32'h0000_5000, 32'h2100, 4'h0);
    check_bit(link_we, 1'b0);
    check_bit(redirect_valid, 1'b0);
    apb(1'b1, jle_pkg::OFF_RETURN_LINK, 32'hDEAD_BEEF);
    rd_chk(jle_pkg::OFF_RETURN_LINK, 32'h0000_2000, 1'b0);
    issue(3'b111, 5'h00, 1'b0, 2'h0, 32'h0000_6000, 32'h3000, 4'h0);
    check_bit(slot_active, 1'b1);
    check_bit(main_status_word[6], 1'b1);
    // Slot at 3000 is never a jump target
    issue(3'b000, 5'h00, 1'b0, 2'h0, 32'h0, 32'h3004, 4'h0);
    check_bit(redirect_valid, 1'b1);
    check_bit(kill_next, 1'b0);
    check_word(redirect_pc, 32'h0000_6000);
    check_word(link_value, 32'h0000_3004);
    check_word(main_status_word, 32'h0);
    end_test("link");
    for (int k = 0; k < 5; k++) begin
      issue(3'b101, 5'h00, 1'b0, 2'h0, 32'h0000_A000, 32'h70, 4'h0);
      check_bit(slot_active, 1'b1);
      issue(k == 0 ? 3'b100 : 3'b000, 5'h00, 1'b0, 2'h0, 32'h0000_B000,
            32'h74, k == 0 ? 4'h0 : 4'(1 << (k - 1)));
      check_bit(fault_illegal_seq, 1'b1);
      check_bit(slot_active, 1'b0);
    end
    rd_chk(jle_pkg::OFF_FAULT, 32'h1, 1'b0);
    apb(1'b1, jle_pkg::OFF_FAULT, 32'h1);
    for (int k = 0; k < 2; k++) begin
      issue(3'b100, 5'h00, k[0], k[0] ? 2'h0 : 2'h1, 32'h9000, 32'h60, 4'h0);
      check_bit(fault_instr_error, 1'b1);
      check_bit(redirect_valid, 1'b0);
    end
    rd_chk(jle_pkg::OFF_FAULT, 32'h2, 1'b0);
    end_test("faults");
    ret_chk(2'h1, 32'h0000_0A42, 32'h0000_8000);
    ret_chk(2'h2, 32'h0000_0504, 32'h0000_8800);
    end_test("interrupt return");
    complete_run();
  end

  // Whole run needs well under 4000 cycles
  initial begin
    repeat (20000) @(posedge pclk);
    errors++;
    $display("MISMATCH at %0t: watchdog expired", $time);
    complete_run();
  end
endmodule
